// ---- rst_ctrl_params.svh ----
// constants for the reset, nmi and power-down control block
`ifndef RST_CTRL_PARAMS_SVH
`define RST_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SPIKE_REJECT_NS 10
`define SPIKE_PASS_NS 100
// samples that must agree: a spike under the reject time covers one edge at most
`define FILT_CYC ((`SPIKE_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define SYNC_CYC 2
// internal reset sequence length in cycles
`define SEQ_CYC 64
// wait for the released pin to come back through sync and filter
`define SETTLE_CYC (`SYNC_CYC + `FILT_CYC + 1)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADR_W 8
`define OFS_SYSCFG 8'h00
`define OFS_CAUSE 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C
`define OFS_CTRL 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_BIDIR 0
`define BIT_INIT 1
`define BIT_PDOWN 2
`define BIT_BOOT 3
`define BIT_SWRST 0
`define EVT_NMI 0
`define EVT_PD_REFUSED 1
`define EVT_RST_DONE 2
`define EVT_W 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_STATUS 3'h0
`define RST_MASK 3'h0

`endif

// ---- rst_ctrl_pkg.sv ----
// types shared by the reset, nmi and power-down control block
package rst_ctrl_pkg;

    // control state, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_HWHOLD = 5'h02,
        ST_SEQ = 5'h04,
        ST_SETTLE = 5'h08,
        ST_PDOWN = 5'h10
    } state_t;

    // last reset cause as reported to software
    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_HW_LONG = 2'h1,
        CAUSE_SW = 2'h2,
        CAUSE_DOG = 2'h3
    } cause_t;

endpackage

// ---- pin_sync_filter.sv ----
// two-flop synchroniser followed by a stable-level spike filter
`include "rst_ctrl_params.svh"

module pin_sync_filter #(
    parameter int FILT_CYC = `FILT_CYC,
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin side
    input wire logic pin_i,
    // filtered level and unfiltered synchronised level
    output logic level_o,
    output logic sync_o
);

    if (FILT_CYC < 1 || FILT_CYC * `CLK_PERIOD_NS > `SPIKE_PASS_NS) begin : g_bad_filt
        $error("filter length out of range");
    end

    localparam int CW = $clog2(FILT_CYC + 1);

    logic s1;
    logic s2;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_level;

    // ------------------------------------------------------------
    // synchroniser, first flop feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
        end
    end

    // level changes only after FILT_CYC equal differing samples
    always_comb begin
        next_cnt = '0;
        next_level = level_o;
        if (s2 != level_o) begin
            if (cnt == CW'(FILT_CYC - 1)) begin
                next_level = s2; // R2
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            level_o <= RST_VAL;
        end else begin
            cnt <= next_cnt;
            level_o <= next_level;
        end
    end

    assign sync_o = s2;

    // a new level was seen on the synchronised input just before
    AST_FILT_STABLE: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        $changed(level_o) |-> $past(s2) == level_o)
        else $error("filter passed an unstable level");

endmodule

// ---- reset_nmi_powerdown_control.sv ----
// reset pin handling, reset sequencing, nmi entry and power-down gating
`include "rst_ctrl_params.svh"

// Function
// R1 - a low reset pin with running clock puts the device into reset
// R2 - reset pin spike filter drops pulses under 10 ns, passes over 100 ns
// R3 - the source holds the reset pin low at least 100 ns plus two clocks
// R4 - with bidirectional reset on, the device pulls its reset pin low all sequence
// R5 - reset indication goes low on any reset and stays low until end of init
// R6 - a falling nmi pin edge sends the cpu to the nmi trap
// R7 - power-down instruction enters power-down only while the nmi pin is low
// R8 - power-down instruction with nmi pin high is ignored
// R9 - bidirectional enable is locked after end of init, cleared by any reset
// R10 - with bidirectional reset on, the cause reads as long hardware reset
// R11 - with bidirectional reset on, port zero straps sample; boot low bit selects loader
// R12 - external reset sources use open-drain outputs when bidirectional reset is on
// R13 - with bidirectional reset on, a short hardware reset lasts the full sequence
// R14 - the source holds reset about 1 ms for straps and clock multiplier; the bench has the source hold the pin 12 cycles at most
module reset_nmi_powerdown_control #(
    parameter int SEQ_CYC = `SEQ_CYC,
    parameter int FILT_CYC = `FILT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // device pins
    input wire logic reset_input_pin_i,
    output logic reset_input_pin_o,
    output logic reset_input_pin_oe_o,
    output logic reset_indication_output_n_o,
    input wire logic nmi_pin_i,
    input wire logic parallel_port_zero_low_bit4_boot_select_i,
    // core side
    input wire logic watchdog_timer_reset_i,
    input wire logic end_of_init_instruction_i,
    input wire logic power_down_instruction_i,
    output logic internal_reset_o,
    output logic nmi_trap_o,
    output logic power_down_o,
    output logic boot_loader_o,
    // interrupt
    output logic irq_o
);

    localparam int SETTLE = `SETTLE_CYC;
    localparam int CW = $clog2(SEQ_CYC + 1);

    if (SEQ_CYC < SETTLE || FILT_CYC < 1) begin : g_bad_par
        $error("sequence or filter length out of range");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    rst_ctrl_pkg::state_t state;
    rst_ctrl_pkg::state_t next_state;
    rst_ctrl_pkg::cause_t cause;
    rst_ctrl_pkg::cause_t next_cause;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic bidir;
    logic next_bidir;
    logic init_done;
    logic next_init;
    logic boot;
    logic next_boot;
    logic drive;
    logic next_drive;
    logic trap;
    logic next_trap;
    logic nmi_prev;
    logic rst_filt;
    logic nmi_filt;
    logic p0_sync;
    logic rst_lo;
    logic nmi_fall;
    logic go_rst;
    logic finish;
    logic refuse;
    logic sw_req;
    logic next_sw;
    logic next_ack;
    logic [31:0] next_dat;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] next_status;
    logic [`EVT_W-1:0] mask;
    logic [`EVT_W-1:0] next_mask;
    logic [`EVT_W-1:0] evt;
    logic wr;
    logic wr_cfg;

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    pin_sync_filter #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_rst_filt ( // R2
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(reset_input_pin_i),
        .level_o(rst_filt),
        .sync_o()
    );

    pin_sync_filter #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_nmi_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(nmi_pin_i),
        .level_o(nmi_filt),
        .sync_o()
    );

    pin_sync_filter #(.FILT_CYC(1), .RST_VAL(1'b1)) u_p0_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(parallel_port_zero_low_bit4_boot_select_i),
        .level_o(),
        .sync_o(p0_sync)
    );

    // event decode
    assign rst_lo = !rst_filt;
    assign nmi_fall = nmi_prev && !nmi_filt;
    assign go_rst = (state == rst_ctrl_pkg::ST_RUN && (rst_lo || sw_req || watchdog_timer_reset_i))
        || (state == rst_ctrl_pkg::ST_PDOWN && rst_lo); // R1
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign wr_cfg = wr && adr_i == `OFS_SYSCFG;

    // ------------------------------------------------------------
    // reset sequencer and power-down control
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cause = cause;
        next_bidir = bidir;
        next_init = init_done;
        next_boot = boot;
        next_trap = 1'b0;
        finish = 1'b0;
        refuse = 1'b0;
        case (state)
            rst_ctrl_pkg::ST_RUN: begin
                if (wr_cfg && !init_done) begin
                    next_bidir = dat_i[`BIT_BIDIR]; // R9
                end
                if (end_of_init_instruction_i) begin
                    next_init = 1'b1; // R5
                end
                next_trap = nmi_fall; // R6
                if (power_down_instruction_i) begin
                    if (!nmi_filt) begin
                        next_state = rst_ctrl_pkg::ST_PDOWN; // R7
                    end else begin
                        refuse = 1'b1; // R8
                    end
                end
            end
            rst_ctrl_pkg::ST_HWHOLD: begin
                if (!rst_lo) begin
                    next_state = rst_ctrl_pkg::ST_SEQ;
                    next_cnt = '0;
                end
            end
            rst_ctrl_pkg::ST_SEQ: begin
                if (cnt == CW'(SEQ_CYC - 1)) begin
                    next_cnt = '0;
                    if (bidir) begin
                        next_state = rst_ctrl_pkg::ST_SETTLE;
                    end else begin
                        finish = 1'b1;
                    end
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            rst_ctrl_pkg::ST_SETTLE: begin
                // pin still held low from outside keeps us here
                if (cnt != CW'(SETTLE - 1)) begin
                    next_cnt = cnt + 1'b1;
                end else if (!rst_lo) begin
                    finish = 1'b1;
                end
            end
            rst_ctrl_pkg::ST_PDOWN: begin
                next_state = rst_ctrl_pkg::ST_PDOWN;
            end
            default: begin
                next_state = rst_ctrl_pkg::ST_SEQ;
                next_cnt = '0;
            end
        endcase
        // any reset source starts a sequence from run, only the reset pin from power-down
        if (go_rst) begin
            next_init = 1'b0; // R5
            next_cnt = '0;
            next_trap = 1'b0;
            refuse = 1'b0;
            next_state = (rst_lo && !bidir) ? rst_ctrl_pkg::ST_HWHOLD
                : rst_ctrl_pkg::ST_SEQ; // R13
            if (rst_lo || bidir) begin
                next_cause = rst_ctrl_pkg::CAUSE_HW_LONG; // R10
            end else if (sw_req) begin
                next_cause = rst_ctrl_pkg::CAUSE_SW;
            end else begin
                next_cause = rst_ctrl_pkg::CAUSE_DOG;
            end
        end
        // end of sequence
        if (finish) begin
            next_state = rst_ctrl_pkg::ST_RUN;
            next_bidir = 1'b0; // R9
            if (cause == rst_ctrl_pkg::CAUSE_HW_LONG) begin
                next_boot = !p0_sync; // R11
            end
        end
        next_drive = next_state == rst_ctrl_pkg::ST_SEQ && next_bidir; // R4
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= rst_ctrl_pkg::ST_SEQ;
            cnt <= '0;
            cause <= rst_ctrl_pkg::CAUSE_HW_LONG;
            bidir <= 1'b0;
            init_done <= 1'b0;
            boot <= 1'b0;
            drive <= 1'b0;
            trap <= 1'b0;
            nmi_prev <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cause <= next_cause;
            bidir <= next_bidir;
            init_done <= next_init;
            boot <= next_boot;
            drive <= next_drive;
            trap <= next_trap;
            nmi_prev <= nmi_filt;
        end
    end

    // pin and core outputs
    assign reset_input_pin_o = 1'b0;
    assign reset_input_pin_oe_o = drive; // R4
    assign reset_indication_output_n_o = init_done; // R5
    assign internal_reset_o = state != rst_ctrl_pkg::ST_RUN
        && state != rst_ctrl_pkg::ST_PDOWN; // R1
    assign power_down_o = state == rst_ctrl_pkg::ST_PDOWN;
    assign nmi_trap_o = trap;
    assign boot_loader_o = boot;

    // ------------------------------------------------------------
    // interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[`EVT_NMI] = trap;
        evt[`EVT_PD_REFUSED] = refuse;
        evt[`EVT_RST_DONE] = finish;
        next_status = status;
        if (wr && adr_i == `OFS_STATUS) begin
            next_status = status & ~dat_i[`EVT_W-1:0];
        end
        next_status = next_status | evt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= `RST_STATUS;
        end else begin
            status <= next_status;
        end
    end

    assign irq_o = |(status & mask);

    // ------------------------------------------------------------
    // wishbone slave, one wait cycle, unmapped reads zero
    // ------------------------------------------------------------
    always_comb begin
        next_ack = cyc_i && stb_i && !ack_o;
        next_mask = mask;
        next_sw = 1'b0;
        next_dat = '0;
        if (wr && adr_i == `OFS_MASK) begin
            next_mask = dat_i[`EVT_W-1:0];
        end
        if (wr && adr_i == `OFS_CTRL) begin
            next_sw = dat_i[`BIT_SWRST];
        end
        case (adr_i)
            `OFS_SYSCFG: begin
                next_dat[`BIT_BIDIR] = bidir;
                next_dat[`BIT_INIT] = init_done;
                next_dat[`BIT_PDOWN] = power_down_o;
                next_dat[`BIT_BOOT] = boot;
            end
            `OFS_CAUSE: next_dat[1:0] = cause;
            `OFS_STATUS: next_dat[`EVT_W-1:0] = status;
            `OFS_MASK: next_dat[`EVT_W-1:0] = mask;
            default: next_dat = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
            mask <= `RST_MASK;
            sw_req <= 1'b0;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
            mask <= next_mask;
            sw_req <= next_sw;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_HW_ENTER: assert property ( // R1
        state == rst_ctrl_pkg::ST_RUN && rst_lo |=> internal_reset_o ##1 internal_reset_o)
        else $error("low reset pin did not reset");
    AST_BIDIR_DRIVE: assert property ( // R4
        state == rst_ctrl_pkg::ST_SEQ && bidir |-> reset_input_pin_oe_o)
        else $error("reset pin not driven during sequence");
    AST_RSTIND: assert property ( // R5
        internal_reset_o |-> !reset_indication_output_n_o)
        else $error("reset indication high during reset");
    AST_NMI_TRAP: assert property ( // R6
        $fell(nmi_filt) && state == rst_ctrl_pkg::ST_RUN && !go_rst |=> nmi_trap_o)
        else $error("nmi edge gave no trap");
    AST_PD_ENTER: assert property ( // R7
        state == rst_ctrl_pkg::ST_RUN && power_down_instruction_i && !nmi_filt && !go_rst
        |=> power_down_o)
        else $error("power-down not entered");
    AST_PD_REFUSE: assert property ( // R8
        state == rst_ctrl_pkg::ST_RUN && power_down_instruction_i && nmi_filt && !go_rst
        |=> !power_down_o && status[`EVT_PD_REFUSED])
        else $error("power-down taken with nmi high");
    AST_BIDIR_LOCK: assert property ( // R9
        init_done && state == rst_ctrl_pkg::ST_RUN |=> $stable(bidir))
        else $error("bidirectional enable changed after init");
    AST_CAUSE_HW: assert property ( // R10
        state == rst_ctrl_pkg::ST_SEQ && bidir |-> cause == rst_ctrl_pkg::CAUSE_HW_LONG)
        else $error("cause not long hardware reset");
    AST_BOOT: assert property ( // R11
        finish && cause == rst_ctrl_pkg::CAUSE_HW_LONG |=> boot_loader_o == !$past(p0_sync))
        else $error("boot strap not sampled");

endmodule

// ---- reset_source_model.sv ----
// open-drain reset source and nmi driver facing the control block
module reset_source_model (
    // clock
    input wire logic clk_i,
    // bench commands
    input wire logic start_i,
    input wire logic [15:0] len_i,
    input wire logic nmi_level_i,
    // device side
    input wire logic dev_oe_i,
    output logic pin_o,
    output logic nmi_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt = 16'h0000;

    // hold the line low for the commanded number of cycles
    always @(posedge clk_i) begin
        if (start_i) begin
            cnt <= len_i;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end
    end

    // only ever pulls low, the pull-up wins otherwise
    assign busy_o = (cnt != 16'h0000);
    assign pin_o = ~(busy_o | dev_oe_i);
    assign nmi_o = nmi_level_i;
endmodule

// ---- reset_nmi_powerdown_control_bench.sv ----
// self-checking bench for the reset, nmi and power-down control block
`include "rst_ctrl_params.svh"

module reset_nmi_powerdown_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int SEQ = 8;
    typedef struct {
        logic [7:0] adr;
        logic [31:0] exp;
    } row_t;
    row_t rows [6];
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic [3:0] sel = 4'hF;
    logic nmi_lvl = 1'b1;
    logic strap = 1'b1;
    logic dog = 1'b0;
    logic eoi = 1'b0;
    logic pd = 1'b0;
    logic start = 1'b0;
    logic [15:0] len = 16'h0000;
    logic [31:0] rdat;
    logic ack, pin, oe, ind_n, nmi, irst, trap, pdn, boot, irq, busy, pin_drv;
    int errors = 0;
    int checked = 0;
    int cnt;

    // ----------------------------------------------------------------
    // design and far side
    // ----------------------------------------------------------------
    reset_nmi_powerdown_control #(.SEQ_CYC(SEQ)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
        .reset_input_pin_i(pin), .reset_input_pin_o(pin_drv), .reset_input_pin_oe_o(oe),
        .reset_indication_output_n_o(ind_n), .nmi_pin_i(nmi),
        .parallel_port_zero_low_bit4_boot_select_i(strap), .watchdog_timer_reset_i(dog),
        .end_of_init_instruction_i(eoi), .power_down_instruction_i(pd),
        .internal_reset_o(irst), .nmi_trap_o(trap), .power_down_o(pdn),
        .boot_loader_o(boot), .irq_o(irq)
    );
    reset_source_model i_partner (
        .clk_i(clk_i), .start_i(start), .len_i(len), .nmi_level_i(nmi_lvl),
        .dev_oe_i(oe), .pin_o(pin), .nmi_o(nmi), .busy_o(busy)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic wishbone cycle, waits for ack under a bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        q = rdat;
        check("wb_ack", 32'(ack), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, q);
        check(name, q, exp);
    endtask

    task automatic hold_pin(input logic [15:0] n);
        start <= 1'b1;
        len <= n;
        @(posedge clk_i);
        start <= 1'b0;
    endtask

    task automatic wait_rst();
        int c;
        c = 0;
        while (irst !== 1'b1 && c < 30) begin
            @(posedge clk_i);
            c++;
        end
        check("reset_entry", 32'(irst), 32'h1);
    endtask

    // counts the cycles the internal reset stays up
    task automatic wait_run(output int c);
        c = 0;
        while (irst !== 1'b0 && c < 300) begin
            @(posedge clk_i);
            c++;
        end
        check("reset_exit", 32'(irst), 32'h0);
    endtask

    task automatic test_done();
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        check("watchdog", 32'h0, 32'h1);
        test_done();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows[0] = '{`OFS_SYSCFG, 32'h00000000};
        rows[1] = '{`OFS_CAUSE, 32'h00000001};
        rows[2] = '{`OFS_STATUS, 32'h00000004};
        rows[3] = '{`OFS_MASK, 32'h00000000};
        rows[4] = '{`OFS_CTRL, 32'h00000000};
        rows[5] = '{8'h20, 32'h00000000};
        repeat (6) @(posedge clk_i);
        check("reset_hold", 32'({irst, ind_n, oe, pdn}), 32'h8);
        rst_i <= 1'b0;
        wait_run(cnt);
        foreach (rows[i]) begin
            rd(rows[i].adr, rows[i].exp, "reg_row");
        end
        // interrupt raised, masked in, cleared
        wr(`OFS_MASK, 32'h00000007);
        rd(`OFS_MASK, 32'h00000007, "mask");
        check("irq_set", 32'(irq), 32'h1);
        wr(`OFS_STATUS, 32'h00000004);
        rd(`OFS_STATUS, 32'h00000000, "status_clr");
        check("irq_clr", 32'(irq), 32'h0);
        // power-down with nmi high is refused
        pd <= 1'b1;
        @(posedge clk_i);
        pd <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("pd_refused", 32'(pdn), 32'h0);
        rd(`OFS_STATUS, 32'h00000002, "status_pd");
        // nmi falling edge gives exactly one trap pulse
        nmi_lvl <= 1'b0;
        cnt = 0;
        repeat (8) begin
            @(posedge clk_i);
            if (trap === 1'b1) cnt++;
        end
        check("nmi_trap", 32'(cnt), 32'h1);
        rd(`OFS_STATUS, 32'h00000003, "status_nmi");
        // power-down with nmi low, left by the reset pin
        pd <= 1'b1;
        @(posedge clk_i);
        pd <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("pd_enter", 32'(pdn), 32'h1);
        hold_pin(16'h000C);
        wait_rst();
        check("pd_exit", 32'(pdn), 32'h0);
        wait_run(cnt);
        rd(`OFS_CAUSE, 32'h00000001, "cause_pin");
        nmi_lvl <= 1'b1;
        // bidirectional mode, watchdog reset
        wr(`OFS_SYSCFG, 32'h00000001);
        rd(`OFS_SYSCFG, 32'h00000001, "bidir_set");
        strap <= 1'b0;
        dog <= 1'b1;
        @(posedge clk_i);
        dog <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("bidir_drive", 32'({oe, ind_n}), 32'h2);
        wait_run(cnt);
        rd(`OFS_CAUSE, 32'h00000001, "cause_bidir");
        rd(`OFS_SYSCFG, 32'h00000008, "syscfg_boot");
        check("boot_loader", 32'(boot), 32'h1);
        // short pin pulse in bidirectional mode is stretched
        strap <= 1'b1;
        wr(`OFS_SYSCFG, 32'h00000001);
        hold_pin(16'h0004);
        wait_rst();
        check("stretch_drive", 32'({oe, busy, pin_drv}), 32'h4);
        wait_run(cnt);
        check("stretch", 32'(cnt >= SEQ), 32'h1);
        rd(`OFS_CAUSE, 32'h00000001, "cause_short");
        // end of init releases the indication and locks the enable
        check("ind_low", 32'(ind_n), 32'h0);
        eoi <= 1'b1;
        @(posedge clk_i);
        eoi <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("ind_high", 32'(ind_n), 32'h1);
        wr(`OFS_SYSCFG, 32'h00000001);
        rd(`OFS_SYSCFG, 32'h00000002, "bidir_lock");
        // software and watchdog resets without bidirectional mode
        wr(`OFS_CTRL, 32'h00000001);
        wait_rst();
        check("ind_sw", 32'({oe, ind_n}), 32'h0);
        wait_run(cnt);
        rd(`OFS_CAUSE, 32'h00000002, "cause_sw");
        dog <= 1'b1;
        @(posedge clk_i);
        dog <= 1'b0;
        wait_rst();
        wait_run(cnt);
        rd(`OFS_CAUSE, 32'h00000003, "cause_dog");
        // cold reset in mid-run clears status and mask, then reruns the sequence
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("reset_mid", 32'({irst, ind_n, oe, irq}), 32'h8);
        rst_i <= 1'b0;
        wait_run(cnt);
        rd(`OFS_STATUS, 32'h00000004, "status_mid");
        test_done();
    end
endmodule
